// [verilog/dblc_pkg.sv]
// Constants for the dual buck LED control register bank.
// Assumes a serial front end that delivers decoded 5-bit addresses,
// 10-bit data and one-cycle write and read strobes on clk.
package dblc_pkg;
   localparam int DW = 10;
   localparam int AW = 5;
   localparam logic [AW-1:0] ADDR_NOP = 5'h00;
   localparam logic [AW-1:0] ADDR_PEAK1 = 5'h01;
   localparam logic [AW-1:0] ADDR_PEAK2 = 5'h02;
   localparam logic [AW-1:0] ADDR_RANGE = 5'h03;
   localparam logic [AW-1:0] ADDR_OFF_TIME = 5'h04;
   localparam logic [AW-1:0] ADDR_GENERAL = 5'h05;
   localparam logic [AW-1:0] ADDR_SYNC_LS = 5'h06;
   localparam logic [AW-1:0] ADDR_THERMAL = 5'h07;
   localparam logic [AW-1:0] ADDR_MEAS = 5'h08;
   localparam logic [AW-1:0] ADDR_TRIM1 = 5'h09;
   localparam logic [AW-1:0] ADDR_TRIM2 = 5'h0a;
   localparam logic [AW-1:0] ADDR_ADC_OTP = 5'h0b;
   localparam logic [AW-1:0] ADDR_BANK_RNG = 5'h18;
   localparam logic [AW-1:0] ADDR_BANK_D12 = 5'h19;
   localparam logic [AW-1:0] ADDR_BANK_D34 = 5'h1a;
   localparam logic [DW-1:0] RST_ZERO = 10'h000;
   localparam logic [7:0] RST_THERMAL_WARN = 8'hb3;
   localparam logic [2:0] RANGE_MAX = 3'h4;
   // Off-time table in units of 0.01 us.V
   localparam int OFFT_BITS = 13;
   localparam logic [OFFT_BITS-1:0] OFF_TIME_TAB [32] = '{
      13'd5000, 13'd4640, 13'd4310, 13'd4000, 13'd3710, 13'd3450, 13'd3200, 13'd2970,
      13'd2760, 13'd2560, 13'd2380, 13'd2210, 13'd2050, 13'd1900, 13'd1770, 13'd1640,
      13'd1520, 13'd1410, 13'd1310, 13'd1220, 13'd1130, 13'd1050, 13'd975, 13'd905,
      13'd841, 13'd780, 13'd725, 13'd673, 13'd625, 13'd580, 13'd538, 13'd500};
   // ADC scale in units of 0.1 mV per count, full range in volts
   localparam logic [11:0] ADC_SCALE_TAB [4] = '{12'd2745, 12'd1961, 12'd1569, 12'd1176};
   localparam logic [6:0] ADC_FULL_TAB [4] = '{7'd70, 7'd50, 7'd40, 7'd30};
   localparam int MEAS_TICK_US = 32;
   localparam int CLK_MHZ = 250;
   localparam int MEAS_TICK_CYC = MEAS_TICK_US * CLK_MHZ;
   localparam int DEAD_TIME_NS = 30;
   localparam logic [1:0] OTP_REFRESH = 2'b01;
   localparam logic [1:0] OTP_ZAP = 2'b10;
   typedef enum logic [1:0] {
      DBLC_NOW_ADAPT30 = 2'b00,
      DBLC_NOW_ADAPT1P = 2'b01,
      DBLC_NOW_FIX2P5 = 2'b10,
      DBLC_NOW_FIX5P = 2'b11
   } dblc_nonoverlap_e;
   typedef enum logic [1:0] {
      DBLC_MEAS_IDLE = 2'b00,
      DBLC_MEAS_WAIT = 2'b01,
      DBLC_MEAS_FIRE = 2'b11
   } dblc_meas_e;
endpackage

// [verilog/dblc_persist.sv]
// Over-current persistence filter for one channel.
// Assumes a one-cycle period strobe and an over-current level on clk.
module dblc_persist
   import dblc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Setting and inputs
   input wire logic [1:0] persist_count,
   input wire logic period_tick,
   input wire logic oc_level,
   // Result
   output logic oc_valid
);
   typedef struct packed {
      logic [2:0] cnt;
      logic valid;
   } dblc_pst_s;
   dblc_pst_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (!oc_level) begin
         s_d.cnt = 3'h0;
         s_d.valid = 1'b0;
      end else if (period_tick) begin
         // Valid only after more than code plus one periods
         if (s_q.cnt > {1'b0, persist_count}) begin
            s_d.valid = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign oc_valid = s_q.valid;
endmodule

// [verilog/dblc_regs.sv]
// Control register bank of the dual buck LED driver.
// Assumes a serial front end that has checked framing and parity and
// presents a write or read strobe with address and data; readback data
// is registered and valid the cycle after the read strobe.
module dblc_regs
   import dblc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port from the serial front end
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata,
   output logic rvalid,
   // Stored trim constants (non-volatile side)
   input wire logic [6:0] ch1_stored_trim_const,
   input wire logic [6:0] ch2_stored_trim_const,
   input wire logic [7:0] ch1_trim_d12,
   input wire logic [7:0] ch2_trim_d12,
   input wire logic [7:0] ch1_trim_d34,
   input wire logic [7:0] ch2_trim_d34,
   input wire logic [5:0] temp_adc_offset_trim,
   input wire logic temp_trim_parity,
   input wire logic trim_load,
   // Regulator feedback
   input wire logic ch1_period_tick,
   input wire logic ch2_period_tick,
   input wire logic ch1_oc_level,
   input wire logic ch2_oc_level,
   // Peak current control
   output logic [2:0] ch1_peak_range_sel,
   output logic [2:0] ch2_peak_range_sel,
   output logic [8:0] ch1_peak_value,
   output logic [8:0] ch2_peak_value,
   output logic [OFFT_BITS-1:0] ch1_off_time,
   output logic [OFFT_BITS-1:0] ch2_off_time,
   output logic ch1_offset_cancel_off,
   output logic ch2_offset_cancel_off,
   output logic slow_edge_select,
   output logic ch1_oc_valid,
   output logic ch2_oc_valid,
   // Mode and enables
   output logic failsafe_operation,
   output logic failsafe_otp_load,
   output logic failsafe_serial_update,
   output logic standalone_mode,
   output logic ch1_enable,
   output logic ch2_enable,
   output logic sync_master_slave,
   output logic [1:0] ch1_nonoverlap_mode,
   output logic [1:0] ch2_nonoverlap_mode,
   output logic ch1_lowside_predriver_on,
   output logic ch2_lowside_predriver_on,
   output logic ch1_reverse_current_hold,
   output logic ch2_reverse_current_hold,
   // Thermal and measurement
   output logic ch1_thermal_auto_restart,
   output logic ch2_thermal_auto_restart,
   output logic [7:0] thermal_warn_level,
   output logic measure_strobe,
   output logic [6:0] ch1_current_trim_code,
   output logic [6:0] ch2_current_trim_code,
   output logic [11:0] ch1_adc_scale,
   output logic [11:0] ch2_adc_scale,
   output logic [6:0] ch1_adc_full_range,
   output logic [6:0] ch2_adc_full_range,
   output logic otp_bias_high,
   output logic otp_bias_low,
   output logic [1:0] otp_addr,
   output logic otp_refresh_pulse,
   output logic otp_zap_pulse
);
   typedef struct packed {
      logic [8:0] peak1;
      logic [8:0] peak2;
      logic [DW-1:0] range;
      logic [2:0] range1_act;
      logic [2:0] range2_act;
      logic [DW-1:0] off_time;
      logic [DW-1:0] general;
      logic [DW-1:0] sync_ls;
      logic [DW-1:0] thermal;
      logic [8:0] meas;
      logic [6:0] trim1;
      logic [6:0] trim2;
      logic [DW-1:0] adc_otp;
      logic [DW-1:0] rdata;
      logic rvalid;
      logic otp_ref;
      logic otp_zap;
      logic [12:0] meas_cyc;
      logic [8:0] meas_ticks;
      dblc_meas_e meas_st;
      logic meas_stb;
      logic [OFFT_BITS-1:0] off1;
      logic [OFFT_BITS-1:0] off2;
      logic [4:0] fs;
      logic [11:0] sc1;
      logic [11:0] sc2;
      logic [6:0] fr1;
      logic [6:0] fr2;
   } dblc_regs_s;
   dblc_regs_s s_q, s_d;

   // Range codes above four keep the last legal range
   function automatic logic [2:0] legal_range(input logic [2:0] code, input logic [2:0] old);
      legal_range = (code <= RANGE_MAX) ? code : old;
   endfunction

   // Decoded mode bits: fail-safe, otp load, serial update, stand-alone
   function automatic logic [4:0] fs_decode(input logic [2:0] md);
      logic [4:0] r;
      r = 5'h00;
      case (md)
         3'b000: r = 5'b00000;
         3'b001: r = 5'b01000;
         3'b010: r = 5'b10000;
         3'b011: r = 5'b10100;
         3'b100: r = 5'b11000;
         3'b101: r = 5'b11100;
         3'b110: r = 5'b01010;
         3'b111: r = 5'b01110;
         default: r = 5'b00000;
      endcase
      fs_decode = r;
   endfunction

   logic oc1, oc2;

   dblc_persist u_pst1 (
      .clk(clk),
      .nrst(nrst),
      .persist_count(s_q.general[6:5]),
      .period_tick(ch1_period_tick),
      .oc_level(ch1_oc_level),
      .oc_valid(oc1)
   );

   dblc_persist u_pst2 (
      .clk(clk),
      .nrst(nrst),
      .persist_count(s_q.general[6:5]),
      .period_tick(ch2_period_tick),
      .oc_level(ch2_oc_level),
      .oc_valid(oc2)
   );

   logic oc1_q, oc2_q;

   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.otp_ref = 1'b0;
      s_d.otp_zap = 1'b0;
      s_d.meas_stb = 1'b0;
      // Trim words follow the stored constants when they are loaded
      if (trim_load) begin
         s_d.trim1 = ch1_stored_trim_const;
         s_d.trim2 = ch2_stored_trim_const;
      end
      if (wr_stb) begin
         case (addr)
            ADDR_PEAK1: begin
               s_d.peak1 = wdata[8:0];
               // Latched range takes effect on the value write
               s_d.range1_act = legal_range(s_q.range[5:3], s_q.range1_act);
            end
            ADDR_PEAK2: begin
               s_d.peak2 = wdata[8:0];
               s_d.range2_act = legal_range(s_q.range[2:0], s_q.range2_act);
            end
            ADDR_RANGE: s_d.range = {2'b00, wdata[7:0]};
            ADDR_OFF_TIME: s_d.off_time = wdata;
            ADDR_GENERAL: s_d.general = wdata;
            ADDR_SYNC_LS: s_d.sync_ls = wdata;
            ADDR_THERMAL: s_d.thermal = wdata;
            // Only writable fields change; read-only trim bits stay
            ADDR_MEAS: s_d.meas = wdata[8:0];
            ADDR_TRIM1: s_d.trim1 = wdata[6:0];
            ADDR_TRIM2: s_d.trim2 = wdata[6:0];
            ADDR_ADC_OTP: begin
               s_d.adc_otp = wdata;
               s_d.otp_ref = (wdata[1:0] == OTP_REFRESH);
               s_d.otp_zap = (wdata[1:0] == OTP_ZAP);
            end
            default: s_d.rvalid = 1'b0;
         endcase
      end
      if (rd_stb) begin
         s_d.rvalid = 1'b1;
         case (addr)
            ADDR_PEAK1: s_d.rdata = {1'b0, s_q.peak1};
            ADDR_PEAK2: s_d.rdata = {1'b0, s_q.peak2};
            ADDR_RANGE: s_d.rdata = s_q.range;
            ADDR_OFF_TIME: s_d.rdata = s_q.off_time;
            ADDR_GENERAL: s_d.rdata = s_q.general;
            ADDR_SYNC_LS: s_d.rdata = s_q.sync_ls;
            ADDR_THERMAL: s_d.rdata = s_q.thermal;
            ADDR_MEAS: s_d.rdata = {temp_trim_parity, s_q.meas};
            ADDR_TRIM1: s_d.rdata = {temp_adc_offset_trim[2:0], s_q.trim1};
            ADDR_TRIM2: s_d.rdata = {temp_adc_offset_trim[5:3], s_q.trim2};
            ADDR_ADC_OTP: s_d.rdata = s_q.adc_otp;
            // Bank bit picks which channel's constants are seen
            ADDR_BANK_RNG: s_d.rdata = {3'h0, s_q.sync_ls[0] ?
               ch2_stored_trim_const : ch1_stored_trim_const};
            ADDR_BANK_D12: s_d.rdata = {2'h0, s_q.sync_ls[0] ? ch2_trim_d12 : ch1_trim_d12};
            ADDR_BANK_D34: s_d.rdata = {2'h0, s_q.sync_ls[0] ? ch2_trim_d34 : ch1_trim_d34};
            default: s_d.rdata = RST_ZERO;
         endcase
      end
      // Off-time table lookup
      s_d.off1 = OFF_TIME_TAB[s_q.off_time[9:5]];
      s_d.off2 = OFF_TIME_TAB[s_q.off_time[4:0]];
      s_d.fs = fs_decode(s_q.general[4:2]);
      // ADC range scaling, code 11 is the 30 V range
      s_d.sc1 = ADC_SCALE_TAB[s_q.adc_otp[9:8]];
      s_d.sc2 = ADC_SCALE_TAB[s_q.adc_otp[7:6]];
      s_d.fr1 = ADC_FULL_TAB[s_q.adc_otp[9:8]];
      s_d.fr2 = ADC_FULL_TAB[s_q.adc_otp[7:6]];
      // Measurement pacing: zero stops it, else value times 32 us
      case (s_q.meas_st)
         DBLC_MEAS_IDLE: begin
            s_d.meas_cyc = 13'h0;
            s_d.meas_ticks = 9'h0;
            if (s_q.meas != 9'h0) begin
               s_d.meas_st = DBLC_MEAS_WAIT;
            end
         end
         DBLC_MEAS_WAIT: begin
            if (s_q.meas == 9'h0) begin
               s_d.meas_st = DBLC_MEAS_IDLE;
            end else if (s_q.meas_cyc == 13'(MEAS_TICK_CYC - 1)) begin
               s_d.meas_cyc = 13'h0;
               if (s_q.meas_ticks + 9'h1 >= s_q.meas) begin
                  s_d.meas_ticks = 9'h0;
                  s_d.meas_st = DBLC_MEAS_FIRE;
               end else begin
                  s_d.meas_ticks = s_q.meas_ticks + 9'h1;
               end
            end else begin
               s_d.meas_cyc = s_q.meas_cyc + 13'h1;
            end
         end
         DBLC_MEAS_FIRE: begin
            s_d.meas_stb = 1'b1;
            s_d.meas_cyc = 13'h1;
            s_d.meas_st = DBLC_MEAS_WAIT;
         end
         default: s_d.meas_st = DBLC_MEAS_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.thermal <= {2'b00, RST_THERMAL_WARN};
         s_q.off1 <= OFF_TIME_TAB[0];
         s_q.off2 <= OFF_TIME_TAB[0];
         s_q.sc1 <= ADC_SCALE_TAB[0];
         s_q.sc2 <= ADC_SCALE_TAB[0];
         s_q.fr1 <= ADC_FULL_TAB[0];
         s_q.fr2 <= ADC_FULL_TAB[0];
         s_q.meas_st <= DBLC_MEAS_IDLE;
         oc1_q <= 1'b0;
         oc2_q <= 1'b0;
      end else begin
         s_q <= s_d;
         oc1_q <= oc1;
         oc2_q <= oc2;
      end
   end

   // Register-driven outputs
   assign rdata = s_q.rdata;
   assign rvalid = s_q.rvalid;
   assign ch1_peak_range_sel = s_q.range1_act;
   assign ch2_peak_range_sel = s_q.range2_act;
   assign ch1_peak_value = s_q.peak1;
   assign ch2_peak_value = s_q.peak2;
   assign ch1_off_time = s_q.off1;
   assign ch2_off_time = s_q.off2;
   assign ch1_offset_cancel_off = s_q.general[9];
   assign ch2_offset_cancel_off = s_q.general[8];
   assign slow_edge_select = s_q.general[7];
   assign ch1_oc_valid = oc1_q;
   assign ch2_oc_valid = oc2_q;
   assign failsafe_operation = s_q.fs[4];
   assign failsafe_otp_load = s_q.fs[3];
   assign failsafe_serial_update = s_q.fs[2];
   assign standalone_mode = s_q.fs[1];
   assign ch1_enable = s_q.general[1];
   assign ch2_enable = s_q.general[0];
   assign sync_master_slave = s_q.sync_ls[9];
   assign ch1_nonoverlap_mode = s_q.sync_ls[8:7];
   assign ch2_nonoverlap_mode = s_q.sync_ls[6:5];
   assign ch1_lowside_predriver_on = s_q.sync_ls[4];
   assign ch2_lowside_predriver_on = s_q.sync_ls[3];
   assign ch1_reverse_current_hold = s_q.sync_ls[2];
   assign ch2_reverse_current_hold = s_q.sync_ls[1];
   assign ch1_thermal_auto_restart = s_q.thermal[9];
   assign ch2_thermal_auto_restart = s_q.thermal[8];
   assign thermal_warn_level = s_q.thermal[7:0];
   assign measure_strobe = s_q.meas_stb;
   assign ch1_current_trim_code = s_q.trim1;
   assign ch2_current_trim_code = s_q.trim2;
   assign ch1_adc_scale = s_q.sc1;
   assign ch2_adc_scale = s_q.sc2;
   assign ch1_adc_full_range = s_q.fr1;
   assign ch2_adc_full_range = s_q.fr2;
   assign otp_bias_high = s_q.adc_otp[5];
   assign otp_bias_low = s_q.adc_otp[4];
   assign otp_addr = s_q.adc_otp[3:2];
   assign otp_refresh_pulse = s_q.otp_ref;
   assign otp_zap_pulse = s_q.otp_zap;
endmodule

// [tb/dblc_regs_sva.sv]
// Checker for the register bank, bound to its ports.
// Assumes one clock domain and the async active-low reset.
module dblc_regs_sva
   import dblc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic [DW-1:0] rdata,
   input wire logic rvalid,
   // Levels and outputs
   input wire logic temp_trim_parity,
   input wire logic [2:0] ch1_peak_range_sel,
   input wire logic [OFFT_BITS-1:0] ch1_off_time,
   input wire logic slow_edge_select,
   input wire logic failsafe_operation,
   input wire logic [7:0] thermal_warn_level,
   input wire logic [11:0] ch1_adc_scale,
   input wire logic otp_zap_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic pk1, offt, gen, adc, zap;
   assign pk1 = wr_stb && addr == ADDR_PEAK1;
   assign offt = wr_stb && addr == ADDR_OFF_TIME;
   assign gen = wr_stb && addr == ADDR_GENERAL;
   assign adc = wr_stb && addr == ADDR_ADC_OTP;
   assign zap = adc && wdata[1:0] == OTP_ZAP;
   a_range_waits: assert property (
      wr_stb && addr == ADDR_RANGE && !$past(pk1) |=> $stable(ch1_peak_range_sel))
      else $error("range applied early");
   a_offt_map: assert property (
      offt ##1 !offt |=> ch1_off_time == OFF_TIME_TAB[$past(wdata[9:5], 2)])
      else $error("off time mismatch");
   a_slow_edge: assert property (
      gen |=> slow_edge_select == $past(wdata[7]))
      else $error("slope bit mismatch");
   a_fso_off: assert property (
      gen && wdata[4:2] == 3'h0 ##1 !gen |=> !failsafe_operation)
      else $error("fail-safe on for code 0");
   a_warn_level: assert property (
      wr_stb && addr == ADDR_THERMAL |=> thermal_warn_level == $past(wdata[7:0]))
      else $error("warn level mismatch");
   a_parity_ro: assert property (
      rd_stb && addr == ADDR_MEAS |=> rvalid && rdata[9] == $past(temp_trim_parity))
      else $error("parity readback wrong");
   a_adc_30v: assert property (
      adc && wdata[9:8] == 2'h3 ##1 !adc |=> ch1_adc_scale == 12'h498)
      else $error("adc scale wrong");
   a_zap_cause: assert property (
      otp_zap_pulse |-> $past(zap) || $past(zap, 2) || $past(zap, 3))
      else $error("zap without request");
   c_offt: cover property (offt);
   c_zap: cover property (otp_zap_pulse);
   c_parity: cover property (rd_stb && addr == ADDR_MEAS);
endmodule

bind dblc_regs dblc_regs_sva i_dblc_regs_sva (.clk(clk), .nrst(nrst), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
   .temp_trim_parity(temp_trim_parity), .ch1_peak_range_sel(ch1_peak_range_sel),
   .ch1_off_time(ch1_off_time), .slow_edge_select(slow_edge_select),
   .failsafe_operation(failsafe_operation), .thermal_warn_level(thermal_warn_level),
   .ch1_adc_scale(ch1_adc_scale), .otp_zap_pulse(otp_zap_pulse));

// [tb/dblc_host_model.sv]
// Host model issuing register writes and reads.
// Assumes strobes are taken at the rising edge; drives after falling edges.
module dblc_host_model
   import dblc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output logic wr_stb,
   output logic rd_stb,
   output logic [AW-1:0] addr,
   output logic [DW-1:0] wdata,
   input wire logic [DW-1:0] rdata,
   input wire logic rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 5'h00;
      wdata = 10'h000;
   end
   // Idle bus shows inverted values so a stale copy is never read
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(negedge clk);
      wr_stb = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_stb = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic ok);
      @(negedge clk);
      rd_stb = 1'b1;
      addr = a;
      @(negedge clk);
      rd_stb = 1'b0;
      addr = ~a;
      d = rdata;
      ok = rvalid;
   endtask
endmodule

// [tb/dblc_regs_test.sv]
// Self-checking bench for the register bank.
// Assumes the host model drives the port and the checker is bound.
`define CHK(g, e) check(32'(g), 32'(e))
module dblc_regs_test
   import dblc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] TC [4] = '{5'h00, 5'h08, 5'h1e, 5'h1f};
   localparam logic [12:0] TV [4] = '{13'h1388, 13'h0ac8, 13'h021a, 13'h01f4};
   localparam logic [11:0] SC [4] = '{12'hab9, 12'h7a9, 12'h621, 12'h498};
   localparam logic [6:0] FR [4] = '{7'h46, 7'h32, 7'h28, 7'h1e};
   localparam logic [3:0] FS [8] = '{4'h0, 4'h4, 4'h8, 4'ha, 4'hc, 4'he, 4'h5, 4'h7};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic tp = 1'b0;
   logic tl = 1'b0;
   logic [6:0] s1 = 7'h00, s2 = 7'h00;
   logic [7:0] da = 8'h00, db = 8'h00, dc = 8'h00, dd = 8'h00;
   logic [5:0] tt = 6'h00;
   logic [1:0] tick = 2'h0, ocl = 2'h0;
   logic [31:0] seed = 32'h7;
   wire wr_stb, rd_stb, rvalid, mst, rfp, zpp;
   wire [AW-1:0] addr;
   wire [DW-1:0] wdata, rdata, o7;
   wire [1:0] ocv;
   wire [2:0] rg1, rg2;
   wire [8:0] pv1, pv2, o6;
   wire [12:0] of1, of2;
   wire [4:0] o5;
   wire [3:0] fs, ob;
   wire [11:0] sc1, sc2;
   wire [6:0] fr1, fr2, tr1, tr2;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_meas = 0;
   int n_ref = 0;
   int n_zap = 0;
   dblc_host_model i_dblc_host_model (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
   dblc_regs i_dblc_regs (.clk(clk), .nrst(nrst), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
      .ch1_stored_trim_const(s1), .ch2_stored_trim_const(s2), .ch1_trim_d12(da),
      .ch2_trim_d12(db), .ch1_trim_d34(dc), .ch2_trim_d34(dd), .temp_adc_offset_trim(tt),
      .temp_trim_parity(tp), .trim_load(tl), .ch1_period_tick(tick[0]),
      .ch2_period_tick(tick[1]), .ch1_oc_level(ocl[0]), .ch2_oc_level(ocl[1]),
      .ch1_peak_range_sel(rg1), .ch2_peak_range_sel(rg2), .ch1_peak_value(pv1),
      .ch2_peak_value(pv2), .ch1_off_time(of1), .ch2_off_time(of2),
      .ch1_offset_cancel_off(o5[4]), .ch2_offset_cancel_off(o5[3]),
      .slow_edge_select(o5[2]), .ch1_oc_valid(ocv[0]), .ch2_oc_valid(ocv[1]),
      .failsafe_operation(fs[3]), .failsafe_otp_load(fs[2]),
      .failsafe_serial_update(fs[1]), .standalone_mode(fs[0]), .ch1_enable(o5[1]),
      .ch2_enable(o5[0]), .sync_master_slave(o6[8]), .ch1_nonoverlap_mode(o6[7:6]),
      .ch2_nonoverlap_mode(o6[5:4]), .ch1_lowside_predriver_on(o6[3]),
      .ch2_lowside_predriver_on(o6[2]), .ch1_reverse_current_hold(o6[1]),
      .ch2_reverse_current_hold(o6[0]), .ch1_thermal_auto_restart(o7[9]),
      .ch2_thermal_auto_restart(o7[8]), .thermal_warn_level(o7[7:0]),
      .measure_strobe(mst), .ch1_current_trim_code(tr1), .ch2_current_trim_code(tr2),
      .ch1_adc_scale(sc1), .ch2_adc_scale(sc2), .ch1_adc_full_range(fr1),
      .ch2_adc_full_range(fr2), .otp_bias_high(ob[3]), .otp_bias_low(ob[2]),
      .otp_addr(ob[1:0]), .otp_refresh_pulse(rfp), .otp_zap_pulse(zpp));
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      n_meas <= n_meas + int'(mst === 1'b1);
      n_ref <= n_ref + int'(rfp === 1'b1);
      n_zap <= n_zap + int'(zpp === 1'b1);
      // Ceiling well above the long measurement wait
      if (cyc == 60000) begin
         errors++;
         final_report();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [DW-1:0] ex(input logic [AW-1:0] a, input logic [DW-1:0] d);
      if (a == ADDR_MEAS) return {tp, d[8:0]};
      if (a == ADDR_TRIM1) return {tt[2:0], d[6:0]};
      if (a == ADDR_TRIM2) return {tt[5:3], d[6:0]};
      return d;
   endfunction
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic final_report();
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic w(input logic [AW-1:0] a, input logic [DW-1:0] d);
      i_dblc_host_model.wr(a, d);
   endtask
   task automatic r(input logic [AW-1:0] a, input logic [DW-1:0] e,
      input logic [DW-1:0] m = 10'h3ff);
      logic [DW-1:0] d;
      logic ok;
      i_dblc_host_model.rd(a, d, ok);
      `CHK(ok, 1'b1);
      `CHK(d & m, e & m);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk);
         tick = 2'h3;
         @(negedge clk);
         tick = 2'h0;
         repeat (3) @(negedge clk);
      end
   endtask
   initial begin
      logic [DW-1:0] d;
      logic [AW-1:0] a;
      logic [2:0] e1, e2;
      int m0, m1;
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      {s1, s2, da, db} = 30'(rnd());
      {dc, dd, tt, tp} = 23'(rnd());
      `CHK(o7, 10'h0b3);
      `CHK(of1, 13'h1388);
      `CHK(fr1, 7'h46);
      for (int i = 4; i < 11; i++) r(5'(i), ex(5'(i), i == 7 ? 10'h0b3 : 10'h000));
      // Random traffic over the plain read-write words
      repeat (40) begin
         a = 5'(4 + rnd() % 7);
         d = 10'(rnd());
         w(a, d);
         if (a == ADDR_GENERAL) `CHK(o5, {d[9:7], d[1:0]});
         if (a == ADDR_SYNC_LS) `CHK(o6, d[9:1]);
         if (a == ADDR_THERMAL) `CHK(o7, d);
         if (a == ADDR_TRIM1) `CHK(tr1, d[6:0]);
         r(a, ex(a, d));
      end
      e1 = 3'h0;
      e2 = 3'h0;
      for (int c = 0; c < 6; c++) begin
         w(ADDR_RANGE, {4'h0, 3'(c), 3'(5 - c)});
         `CHK({rg1, rg2}, {e1, e2});
         d = 10'(rnd());
         w(ADDR_PEAK1, d);
         if (c < 5) e1 = 3'(c);
         `CHK({rg1, pv1}, {e1, d[8:0]});
         w(ADDR_PEAK2, d);
         if (c > 0) e2 = 3'(5 - c);
         `CHK({rg2, pv2}, {e2, d[8:0]});
      end
      foreach (TC[i]) begin
         w(ADDR_OFF_TIME, {TC[i], TC[3 - i]});
         @(negedge clk);
         `CHK({of1, of2}, {TV[i], TV[3 - i]});
      end
      for (int c = 0; c < 8; c++) begin
         w(ADDR_GENERAL, {5'h00, 3'(c), 2'h3});
         @(negedge clk);
         `CHK(c < 6 ? fs : {1'b0, fs[2:0]}, FS[c]);
      end
      for (int c = 0; c < 4; c++) begin
         d = {2'(c), 2'(3 - c), 4'(rnd()), 2'(c)};
         m0 = n_ref;
         m1 = n_zap;
         w(ADDR_ADC_OTP, d);
         `CHK(ob, d[5:2]);
         repeat (3) @(negedge clk);
         `CHK({sc1, sc2, fr1}, {SC[c], SC[3 - c], FR[c]});
         `CHK(fr2, FR[3 - c]);
         `CHK(n_ref - m0, int'(c == 1));
         `CHK(n_zap - m1, int'(c == 2));
      end
      for (int k = 0; k < 4; k++) begin
         w(ADDR_GENERAL, {3'h0, 2'(k), 5'h00});
         ocl = 2'h3;
         ticks(k + 1);
         `CHK(ocv, 2'h0);
         ticks(1);
         `CHK(ocv, 2'h3);
         ocl = 2'h0;
         ticks(1);
         `CHK(ocv, 2'h0);
      end
      {s1, s2} = 14'(rnd());
      tl = 1'b1;
      @(negedge clk);
      tl = 1'b0;
      @(negedge clk);
      `CHK({tr1, tr2}, {s1, s2});
      r(ADDR_TRIM2, {tt[5:3], s2});
      for (int b = 0; b < 2; b++) begin
         w(ADDR_SYNC_LS, 10'(b));
         r(ADDR_BANK_RNG, {3'h0, b ? s2 : s1}, 10'h07f);
         r(ADDR_BANK_D12, {2'h0, b ? db : da}, 10'h0ff);
         r(ADDR_BANK_D34, {2'h0, b ? dd : dc}, 10'h0ff);
      end
      // Unmapped place: write dropped, read gives zero
      w(5'h0c, 10'h3ff);
      r(5'h0c, 10'h000);
      w(ADDR_MEAS, 10'h000);
      m0 = n_meas;
      repeat (MEAS_TICK_CYC + 100) @(negedge clk);
      `CHK(n_meas - m0, 0);
      w(ADDR_MEAS, 10'h001);
      m0 = n_meas;
      repeat (2 * MEAS_TICK_CYC + 100) @(negedge clk);
      `CHK(n_meas - m0, 2);
      final_report();
   end
endmodule
